// >>> pkg/sync_status_pkg.sv
package sync_status_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int VIT_W  = 9;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_SYNC_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_REALTIME_IRQ = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK     = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STATUS_POL   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_LATCHED_IRQ  = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CTRL     = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_STATUS_MUTE  = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_LOSS_CFG     = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_STATUS_A_SEL = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_STATUS_B_SEL = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_STATUS_DIV   = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_DEV_STATE    = 8'h2C;

    // field positions
    localparam int SYNC_SW_BIT    = 0;
    localparam int SYNC_PLL1_BIT  = 1;
    localparam int SYNC_PLL2_BIT  = 2;
    localparam int MASK_EN_BIT    = 0;
    localparam int MASK_FLD_LO    = 2;
    localparam int MASK_VIT_LO    = 16;
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_OR_BIT    = 1;
    localparam int MUTE_EN_LO     = 0;
    localparam int MUTE_CLK_LO    = 2;
    localparam int MUTE_SRC_LO    = 4;
    localparam int LOSS_PRI_THR   = 0;
    localparam int LOSS_SEC_THR   = 2;
    localparam int LOSS_PRI_EDGE  = 4;
    localparam int LOSS_SEC_EDGE  = 6;
    localparam int DIV_B_LO       = 8;

    localparam logic [2:0] IRQ_FIELD_ON = 3'h7;

    // reset values
    localparam logic       SW_SYNC_RST  = 1'b1;
    localparam logic [3:0] SEL_A_RST    = 4'h2;
    localparam logic [3:0] SEL_B_RST    = 4'h5;

    // vital bit indices
    localparam int V_PRI_LOS = 0;
    localparam int V_SEC_LOS = 1;
    localparam int V_LOL1    = 2;
    localparam int V_LOL2    = 3;
    localparam int V_CAL1    = 4;
    localparam int V_CAL2    = 5;
    localparam int V_EEPROM  = 6;
    localparam int V_SW1     = 7;
    localparam int V_SW2     = 8;

    // sync timing, counted in edges of the slowest output and vco-rate cycles
    localparam logic [1:0] SYNC_FALL_EDGES = 2'h2;
    localparam logic [1:0] SYNC_VCO_CYCLES = 2'h2;
    localparam logic [7:0] LOL_SLIP_LIMIT  = 8'h04;

    // status clock ceiling; half period never below one ref_clk cycle
    localparam int CLK_MHZ         = 250;
    localparam int STATUS_CLK_MHZ  = 200;
    localparam int STATUS_HALF_MIN = (CLK_MHZ + 2*STATUS_CLK_MHZ - 1) / (2*STATUS_CLK_MHZ);

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {SY_IDLE, SY_WAIT_FALL, SY_WAIT_VCO, SY_HELD, SY_RELEASE} sync_state_t;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } axil_req_t;

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } axil_rsp_t;

    typedef struct packed {
        logic [1:0] pri_swing;
        logic [1:0] sec_swing;
        logic       pri_single_ended;
        logic       sec_single_ended;
        logic [1:0] pri_slow_edge;
        logic [1:0] sec_slow_edge;
        logic [1:0] pll_slip;
        logic [1:0] pll_relock;
        logic [1:0] r_div_tick;
        logic [1:0] n_div_tick;
        logic [1:0] m_div_tick;
        logic [1:0] cal_active;
        logic       eeprom_active;
        logic [1:0] auto_switch;
    } vitals_in_t;

    typedef struct packed {
        logic [1:0] divider_reset;
        logic [1:0] driver_enable;
        logic [1:0] vco_div_reset;
    } sync_out_t;

endpackage

// >>> src/output_sync_and_status_monitor.sv
`timescale 1ns/1ps
// Operation
// - sync request low resets the output and post dividers of each sync-enabled pll together
// - request comes from strap pin zero in soft pin mode, else software bit
// - a pll's outputs react only when its sync enable is set and request low
// - request 0 mutes drivers and holds dividers; 1 runs them normally
// - vco divider reset follows two falling edges of slowest output then vco cycles
// - sync latency fixed, varies by at most one vco-rate cycle
// - drivers start and stop only on slowest output's falling edge
// - each status pin not in clock mode shows the vital chosen by its select register
// - codes 0-7: ref losses, pll1 lock/dividers, pll2 lock/dividers
// - codes 8-15: calibration, combined irq, m dividers, eeprom, switchovers
// - status pin events pass through programmable polarity
// - combined irq only with enable bit, field 0x7 and mask bit zero
// - latched sources combine by and or or per control bit
// - masked-out vitals never reach the combined irq
// - latched register readable while enabled, cleared when read completes
// - realtime register tracks vitals always, cleared when read completes
// - differential loss when swing under per-reference two-bit threshold
// - single-ended loss also on slow rising, falling or both edges
// - lock detector counts slips, flags lock loss past limit, resets count
// - status pins as clocks run at independent rates, at most 200 MHz
// - muted status clock holds a static polarity level while pll unlocked
module output_sync_and_status_monitor
    import sync_status_pkg::*;
(
    input  wire logic                       ref_clk,
    input  wire logic                       nrst,
    input  wire sync_status_pkg::axil_req_t axil_req,
    output      sync_status_pkg::axil_rsp_t axil_rsp,
    input  wire logic                       soft_pin_mode,
    input  wire logic                       strap_pin_zero,
    input  wire logic                       slowest_out_clk,
    input  wire sync_status_pkg::vitals_in_t vitals,
    output      sync_status_pkg::sync_out_t sync_out,
    output      logic                       status_pin_a,
    output      logic                       status_pin_b,
    output      logic                       combined_irq_output
);
    import sync_status_pkg::*;

    typedef struct packed {
        logic                   sw_sync;
        logic [1:0]             pll_sync_en;
        logic [1:0]             pol;
        logic [DATA_W-1:0]      mask;
        logic [1:0]             ctrl;
        logic [5:0]             mute_cfg;
        logic [7:0]             loss_cfg;
        logic [1:0][3:0]        sel;
        logic [1:0][7:0]        sdiv;
        logic [1:0][7:0]        scnt;
        logic [1:0]             sclk;
        logic [VIT_W-1:0]       rt;
        logic [VIT_W-1:0]       lat;
        logic [VIT_W-1:0]       vit_q;
        logic [1:0][7:0]        slips;
        logic [1:0]             loss_of_lock_flag;
        logic [5:0]             div_half;
        logic                   slow_q;
        sync_state_t            sy;
        logic [1:0]             sy_cnt;
        logic [1:0]             sy_mask;
        sync_out_t              so;
        logic [1:0]             pins;
        logic                   irq;
        logic                   aw_have;
        logic                   w_have;
        logic [ADDR_W-1:0]      awaddr;
        logic [DATA_W-1:0]      wdata;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [DATA_W-1:0]      rdata;
        logic [1:0]             rresp;
        logic [VIT_W-1:0]       clr_rt;
        logic [VIT_W-1:0]       clr_lat;
    } state_t;

    state_t state_reg;
    state_t state_next;

    ////////////////////////////////////////////////////////////////////////////
    // combinational helpers

    logic                   sync_req_low;
    logic                   slow_fall;
    logic [VIT_W-1:0]       vit_now;
    logic                   pri_los;
    logic                   sec_los;
    logic [VIT_W-1:0]       vit_used;
    logic                   comb_any;
    logic [15:0]            sel_src;
    logic [DATA_W-1:0]      rd_val;
    logic                   rd_ok;

    assign sync_req_low = soft_pin_mode ? strap_pin_zero : state_reg.sw_sync;
    assign slow_fall    = state_reg.slow_q & ~slowest_out_clk;

    // threshold codes: measured swing below programmed code counts as loss
    assign pri_los = (vitals.pri_swing < state_reg.loss_cfg[LOSS_PRI_THR +: 2])
                   | (vitals.pri_single_ended
                      & |(vitals.pri_slow_edge & state_reg.loss_cfg[LOSS_PRI_EDGE +: 2]));
    assign sec_los = (vitals.sec_swing < state_reg.loss_cfg[LOSS_SEC_THR +: 2])
                   | (vitals.sec_single_ended
                      & |(vitals.sec_slow_edge & state_reg.loss_cfg[LOSS_SEC_EDGE +: 2]));

    always_comb begin
        vit_now            = '0;
        vit_now[V_PRI_LOS] = pri_los;
        vit_now[V_SEC_LOS] = sec_los;
        vit_now[V_LOL1]    = state_reg.loss_of_lock_flag[0];
        vit_now[V_LOL2]    = state_reg.loss_of_lock_flag[1];
        vit_now[V_CAL1]    = vitals.cal_active[0];
        vit_now[V_CAL2]    = vitals.cal_active[1];
        vit_now[V_EEPROM]  = vitals.eeprom_active;
        vit_now[V_SW1]     = vitals.auto_switch[0];
        vit_now[V_SW2]     = vitals.auto_switch[1];
    end

    assign vit_used = state_reg.mask[MASK_VIT_LO +: VIT_W];
    // and over an empty set would fire forever, so it needs one used vital
    assign comb_any = state_reg.ctrl[CTRL_OR_BIT] ? |(state_reg.lat & vit_used)
                    : (|vit_used) & &(state_reg.lat | ~vit_used);

    always_comb begin
        sel_src     = '0;
        sel_src[0]  = pri_los;
        sel_src[1]  = sec_los;
        sel_src[2]  = state_reg.loss_of_lock_flag[0];
        sel_src[3]  = state_reg.div_half[0];
        sel_src[4]  = state_reg.div_half[1];
        sel_src[5]  = state_reg.loss_of_lock_flag[1];
        sel_src[6]  = state_reg.div_half[2];
        sel_src[7]  = state_reg.div_half[3];
        sel_src[8]  = vitals.cal_active[0];
        sel_src[9]  = vitals.cal_active[1];
        sel_src[10] = state_reg.irq;
        sel_src[11] = state_reg.div_half[4];
        sel_src[12] = state_reg.div_half[5];
        sel_src[13] = vitals.eeprom_active;
        sel_src[14] = vitals.auto_switch[0];
        sel_src[15] = vitals.auto_switch[1];
    end

    always_comb begin
        rd_val = '0;
        rd_ok  = 1'b1;
        unique case (axil_req.araddr)
            OFF_SYNC_CTRL:    rd_val[2:0] = {state_reg.pll_sync_en, state_reg.sw_sync};
            OFF_REALTIME_IRQ: rd_val[VIT_W-1:0] = state_reg.rt;
            OFF_IRQ_MASK:     rd_val = state_reg.mask;
            OFF_STATUS_POL:   rd_val[1:0] = state_reg.pol;
            OFF_LATCHED_IRQ:  rd_val[VIT_W-1:0] = state_reg.ctrl[CTRL_EN_BIT] ? state_reg.lat : '0;
            OFF_IRQ_CTRL:     rd_val[1:0] = state_reg.ctrl;
            OFF_STATUS_MUTE:  rd_val[5:0] = state_reg.mute_cfg;
            OFF_LOSS_CFG:     rd_val[7:0] = state_reg.loss_cfg;
            OFF_STATUS_A_SEL: rd_val[3:0] = state_reg.sel[0];
            OFF_STATUS_B_SEL: rd_val[3:0] = state_reg.sel[1];
            OFF_STATUS_DIV:   rd_val[15:0] = {state_reg.sdiv[1], state_reg.sdiv[0]};
            OFF_DEV_STATE:    rd_val[VIT_W-1:0] = vit_now;
            default:          rd_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic       rd_take;
        logic       rd_done;
        logic       wr_go;
        logic [1:0] pin_lvl;
        logic [1:0] src_lol;
        state_next = state_reg;
        rd_take    = axil_req.arvalid & ~state_reg.rvalid;
        rd_done    = state_reg.rvalid & axil_req.rready;
        wr_go      = 1'b0;
        pin_lvl    = '0;
        src_lol    = '0;

        // bus: address and data taken in either order, response after both
        if (axil_req.awvalid && !state_reg.aw_have && !state_reg.bvalid) begin
            state_next.aw_have = 1'b1;
            state_next.awaddr  = axil_req.awaddr;
        end
        if (axil_req.wvalid && !state_reg.w_have && !state_reg.bvalid) begin
            state_next.w_have = 1'b1;
            state_next.wdata  = axil_req.wdata;
        end
        if (state_reg.aw_have && state_reg.w_have) begin
            wr_go              = 1'b1;
            state_next.aw_have = 1'b0;
            state_next.w_have  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = RESP_OKAY;
        end
        if (state_reg.bvalid && axil_req.bready) begin
            state_next.bvalid = 1'b0;
        end
        if (wr_go) begin
            // byte lane zero carries every writable field except the upper mask and the status B divider
            unique case (state_reg.awaddr)
                OFF_SYNC_CTRL: begin
                    state_next.sw_sync     = state_reg.wdata[SYNC_SW_BIT];
                    state_next.pll_sync_en = {state_reg.wdata[SYNC_PLL2_BIT], state_reg.wdata[SYNC_PLL1_BIT]};
                end
                OFF_IRQ_MASK:     state_next.mask     = state_reg.wdata;
                OFF_STATUS_POL:   state_next.pol      = state_reg.wdata[1:0];
                OFF_IRQ_CTRL:     state_next.ctrl     = state_reg.wdata[1:0];
                OFF_STATUS_MUTE:  state_next.mute_cfg = state_reg.wdata[5:0];
                OFF_LOSS_CFG:     state_next.loss_cfg = state_reg.wdata[7:0];
                OFF_STATUS_A_SEL: state_next.sel[0]   = state_reg.wdata[3:0];
                OFF_STATUS_B_SEL: state_next.sel[1]   = state_reg.wdata[3:0];
                OFF_STATUS_DIV:   state_next.sdiv     = state_reg.wdata[15:0];
                OFF_REALTIME_IRQ, OFF_LATCHED_IRQ, OFF_DEV_STATE: ;
                default:          state_next.bresp    = RESP_SLVERR;
            endcase
        end

        state_next.clr_rt  = rd_done ? '0 : state_reg.clr_rt;
        state_next.clr_lat = rd_done ? '0 : state_reg.clr_lat;
        if (rd_done) begin
            state_next.rvalid = 1'b0;
        end
        if (rd_take) begin
            state_next.rvalid  = 1'b1;
            state_next.rdata   = rd_val;
            state_next.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
            state_next.clr_rt  = (axil_req.araddr == OFF_REALTIME_IRQ) ? rd_val[VIT_W-1:0] : '0;
            state_next.clr_lat = (axil_req.araddr == OFF_LATCHED_IRQ) ? rd_val[VIT_W-1:0] : '0;
        end

        // only the bits actually returned are cleared; a new set wins
        state_next.vit_q = vit_now;
        state_next.rt  = (state_reg.rt & ~(rd_done ? state_reg.clr_rt : '0)) | vit_now;
        state_next.lat = (state_reg.lat & ~(rd_done ? state_reg.clr_lat : '0))
                       | ((vit_now & ~state_reg.vit_q) & {VIT_W{state_reg.ctrl[CTRL_EN_BIT]}});

        state_next.irq = state_reg.ctrl[CTRL_EN_BIT] && state_reg.mask[MASK_EN_BIT]
                       && (state_reg.mask[MASK_FLD_LO +: 3] == IRQ_FIELD_ON) && comb_any;

        // lock detectors and divided-by-two monitors
        for (int p = 0; p < 2; p++) begin
            if (vitals.pll_slip[p]) begin
                if (state_reg.slips[p] == LOL_SLIP_LIMIT) begin
                    state_next.loss_of_lock_flag[p]   = 1'b1;
                    state_next.slips[p] = '0;
                end else begin
                    state_next.slips[p] = state_reg.slips[p] + 8'h01;
                end
            end else if (vitals.pll_relock[p]) begin
                state_next.loss_of_lock_flag[p] = 1'b0;
            end
            state_next.div_half[2*p]   = state_reg.div_half[2*p] ^ vitals.r_div_tick[p];
            state_next.div_half[2*p+1] = state_reg.div_half[2*p+1] ^ vitals.n_div_tick[p];
            state_next.div_half[4+p]   = state_reg.div_half[4+p] ^ vitals.m_div_tick[p];
        end

        // output synchronisation: fixed edge counts keep latency deterministic
        state_next.slow_q = slowest_out_clk;
        unique case (state_reg.sy)
            SY_IDLE: begin
                if (!sync_req_low && |state_reg.pll_sync_en) begin
                    state_next.sy      = SY_WAIT_FALL;
                    state_next.sy_cnt  = '0;
                    state_next.sy_mask = state_reg.pll_sync_en;
                end
            end
            SY_WAIT_FALL: begin
                if (sync_req_low) begin
                    state_next.sy = SY_IDLE; // too short a pulse does nothing
                end else if (slow_fall) begin
                    if (state_reg.sy_cnt == SYNC_FALL_EDGES - 2'h1) begin
                        state_next.sy                = SY_WAIT_VCO;
                        state_next.sy_cnt            = '0;
                        state_next.so.divider_reset  = state_reg.sy_mask;
                        state_next.so.driver_enable  = ~state_reg.sy_mask;
                    end else begin
                        state_next.sy_cnt = state_reg.sy_cnt + 2'h1;
                    end
                end
            end
            SY_WAIT_VCO: begin
                if (state_reg.sy_cnt == SYNC_VCO_CYCLES - 2'h1) begin
                    state_next.sy               = SY_HELD;
                    state_next.so.vco_div_reset = state_reg.sy_mask;
                end else begin
                    state_next.sy_cnt = state_reg.sy_cnt + 2'h1;
                end
            end
            SY_HELD: begin
                if (sync_req_low) begin
                    state_next.sy = SY_RELEASE;
                end
            end
            SY_RELEASE: begin
                // release on a falling edge so the first high phase is whole
                if (slow_fall) begin
                    state_next.sy = SY_IDLE;
                    state_next.so = '{divider_reset: 2'h0, driver_enable: 2'h3, vco_div_reset: 2'h0};
                end
            end
        endcase

        // status pins: vital mux or independent clock
        for (int s = 0; s < 2; s++) begin
            src_lol[s] = state_reg.loss_of_lock_flag[state_reg.mute_cfg[MUTE_SRC_LO + s]];
            if (state_reg.scnt[s] >= state_reg.sdiv[s] + 8'(STATUS_HALF_MIN - 1)) begin
                state_next.scnt[s] = '0;
                state_next.sclk[s] = ~state_reg.sclk[s];
            end else begin
                state_next.scnt[s] = state_reg.scnt[s] + 8'h01;
            end
            if (state_reg.mute_cfg[MUTE_CLK_LO + s]) begin
                if (state_reg.mute_cfg[MUTE_EN_LO + s] && src_lol[s]) begin
                    pin_lvl[s] = state_reg.pol[s];
                end else begin
                    pin_lvl[s] = state_reg.sclk[s] ^ state_reg.pol[s];
                end
            end else begin
                pin_lvl[s] = sel_src[state_reg.sel[s]] ^ state_reg.pol[s];
            end
        end
        state_next.pins = pin_lvl;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_reg                  <= '0;
            state_reg.sw_sync          <= SW_SYNC_RST;
            state_reg.sel[0]           <= SEL_A_RST;
            state_reg.sel[1]           <= SEL_B_RST;
            state_reg.sy               <= SY_IDLE;
            state_reg.so.driver_enable <= 2'h3;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign axil_rsp.awready    = ~state_reg.aw_have & ~state_reg.bvalid;
    assign axil_rsp.wready     = ~state_reg.w_have & ~state_reg.bvalid;
    assign axil_rsp.bvalid     = state_reg.bvalid;
    assign axil_rsp.bresp      = state_reg.bresp;
    assign axil_rsp.arready    = ~state_reg.rvalid;
    assign axil_rsp.rvalid     = state_reg.rvalid;
    assign axil_rsp.rdata      = state_reg.rdata;
    assign axil_rsp.rresp      = state_reg.rresp;
    assign sync_out            = state_reg.so;
    assign status_pin_a        = state_reg.pins[0];
    assign status_pin_b        = state_reg.pins[1];
    assign combined_irq_output = state_reg.irq;

endmodule

// >>> verification/sync_host_model.sv
`timescale 1ns/1ps
module sync_host_model (
    input  wire logic ref_clk,
    input  wire logic go,
    output logic      strap_pin_zero,
    output logic      slowest_out_clk
);
    logic [2:0] div_cnt = 3'h0;
    logic [5:0] hold_cnt = 6'h0;
    // free running, eight ref cycles a period
    assign slowest_out_clk = div_cnt[2];
    // 40 cycles low: two slow falls plus margin
    assign strap_pin_zero = (hold_cnt == 6'h0);
    always @(posedge ref_clk) begin
        div_cnt <= div_cnt + 3'h1;
        if (go) begin
            hold_cnt <= 6'h28;
        end else if (hold_cnt != 6'h0) begin
            hold_cnt <= hold_cnt - 6'h1;
        end
    end
endmodule

// >>> verification/sync_status_checker.sv
`timescale 1ns/1ps
module sync_status_checker
    import sync_status_pkg::*;
(
    input wire logic                       ref_clk,
    input wire logic                       nrst,
    input wire sync_status_pkg::axil_req_t axil_req,
    input wire sync_status_pkg::axil_rsp_t axil_rsp,
    input wire sync_status_pkg::sync_out_t sync_out
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence vco_soon;
        ##[2:3] $rose(sync_out.vco_div_reset[0]);
    endsequence
    chk_vco_delay: assert property ($rose(sync_out.divider_reset[0]) |-> vco_soon)
        else $error("vco reset not 2 to 3 cycles after divider reset");
    chk_mute_held: assert property (sync_out.divider_reset[0] |-> !sync_out.driver_enable[0])
        else $error("driver on while divider held");
    chk_vco_in_div: assert property (sync_out.vco_div_reset[1] |-> sync_out.divider_reset[1])
        else $error("vco reset without divider reset");
    chk_release_all: assert property ($fell(sync_out.divider_reset[0]) |->
        sync_out.driver_enable[0] && !sync_out.vco_div_reset[0])
        else $error("partial sync release");
    chk_w_answer: assert property (axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
        |-> ##[1:2] axil_rsp.bvalid)
        else $error("write response missing");
    chk_b_once: assert property (axil_rsp.bvalid && axil_req.bready |=> !axil_rsp.bvalid)
        else $error("write response repeated");
    chk_r_answer: assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
        else $error("read data missing");
    chk_r_once: assert property (axil_rsp.rvalid && axil_req.rready |=> !axil_rsp.rvalid)
        else $error("read data repeated");
endmodule
bind output_sync_and_status_monitor sync_status_checker chk_i(.ref_clk(ref_clk), .nrst(nrst),
    .axil_req(axil_req), .axil_rsp(axil_rsp), .sync_out(sync_out));

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import sync_status_pkg::*;
    logic ref_clk = 0, nrst = 0, soft_pin_mode = 0, go = 0;
    logic strap_pin_zero, slowest_out_clk, pin_a, pin_b, irq;
    axil_req_t rq = '{wstrb: 4'hF, bready: 1'b1, rready: 1'b1, default: '0};
    axil_rsp_t rs;
    vitals_in_t vt = '0;
    sync_out_t so;
    int n_mismatch = 0, check_count = 0;
    logic [31:0] d;
    logic [1:0] r;
    always #2 ref_clk = ~ref_clk;
    output_sync_and_status_monitor dut(.ref_clk(ref_clk), .nrst(nrst), .axil_req(rq), .axil_rsp(rs),
        .soft_pin_mode(soft_pin_mode), .strap_pin_zero(strap_pin_zero), .slowest_out_clk(slowest_out_clk),
        .vitals(vt), .sync_out(so), .status_pin_a(pin_a), .status_pin_b(pin_b), .combined_irq_output(irq));
    sync_host_model host(.ref_clk(ref_clk), .go(go), .strap_pin_zero(strap_pin_zero),
        .slowest_out_clk(slowest_out_clk));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", n, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        rq.awaddr <= a;
        rq.wdata <= v;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (rs.awready) rq.awvalid <= 1'b0;
            if (rs.wready) rq.wvalid <= 1'b0;
        end while ((rq.awvalid && !rs.awready) || (rq.wvalid && !rs.wready));
        do @(posedge ref_clk); while (!rs.bvalid);
        r = rs.bresp;
    endtask
    // rready stays high, so the answer is taken at the edge it is seen
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        rq.araddr <= a;
        rq.arvalid <= 1'b1;
        do @(posedge ref_clk); while (!rs.arready);
        rq.arvalid <= 1'b0;
        do @(posedge ref_clk); while (!rs.rvalid);
        d = rs.rdata;
        r = rs.rresp;
        chk("rdata", d, e);
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk("drv_en", so.driver_enable, 2'b11);
        rdc(OFF_SYNC_CTRL, 32'h1);
        rdc(OFF_STATUS_A_SEL, 32'h2);
        rdc(OFF_STATUS_B_SEL, 32'h5);
        rdc(8'h40, 32'h0);
        chk("rresp", r, RESP_SLVERR);
        wr(8'h40, 32'h0);
        chk("bresp", r, RESP_SLVERR);
        $display("test reset done");
    endtask
    task automatic t_sync_pin;
        soft_pin_mode <= 1'b1;
        wr(OFF_SYNC_CTRL, 32'h3);
        go <= 1'b1;
        wait_n(1);
        go <= 1'b0;
        wait_n(30);
        chk("div_vco", {so.divider_reset, so.vco_div_reset}, 4'h5);
        chk("drv_en", so.driver_enable, 2'b10);
        wait_n(40);
        chk("release", {so.divider_reset, so.driver_enable, so.vco_div_reset}, 6'h0C);
        $display("test sync pin done");
    endtask
    task automatic t_sync_sw;
        soft_pin_mode <= 1'b0;
        wr(OFF_SYNC_CTRL, 32'h6);
        wait_n(30);
        chk("sw_sync", {so.divider_reset, so.driver_enable}, 4'hC);
        wr(OFF_SYNC_CTRL, 32'h7);
        wait_n(30);
        chk("sw_free", {so.divider_reset, so.driver_enable}, 4'h3);
        $display("test sync sw done");
    endtask
    task automatic t_status;
        wr(OFF_LOSS_CFG, 32'h2);
        wr(OFF_STATUS_A_SEL, 32'h0);
        wr(OFF_STATUS_B_SEL, 32'hD);
        vt.eeprom_active <= 1'b1;
        wait_n(4);
        chk("pins", {pin_a, pin_b}, 2'b11);
        wr(OFF_STATUS_POL, 32'h1);
        vt.pri_swing <= 2'h3;
        wait_n(4);
        chk("pins_pol", {pin_a, pin_b}, 2'b11);
        vt.eeprom_active <= 1'b0;
        $display("test status done");
    endtask
    task automatic t_irq;
        wr(OFF_IRQ_CTRL, 32'h0);
        vt.cal_active[0] <= 1'b1;
        rdc(OFF_REALTIME_IRQ, 32'h51);
        rdc(OFF_REALTIME_IRQ, 32'h10);
        rdc(OFF_LATCHED_IRQ, 32'h0);
        vt.cal_active[0] <= 1'b0;
        wr(OFF_IRQ_MASK, 32'h0050001D);
        wr(OFF_IRQ_CTRL, 32'h1);
        vt.cal_active[0] <= 1'b1;
        wait_n(2);
        vt.cal_active[0] <= 1'b0;
        wait_n(3);
        chk("irq_and", irq, 1'b0);
        wr(OFF_IRQ_CTRL, 32'h3);
        wait_n(3);
        chk("irq_or", irq, 1'b1);
        wr(OFF_IRQ_MASK, 32'h0040001D);
        wait_n(3);
        chk("irq_mask", irq, 1'b0);
        wr(OFF_IRQ_MASK, 32'h0050001C);
        wait_n(3);
        chk("irq_off", irq, 1'b0);
        rdc(OFF_LATCHED_IRQ, 32'h10);
        rdc(OFF_LATCHED_IRQ, 32'h0);
        wr(OFF_STATUS_B_SEL, 32'h2);
        vt.pll_slip[0] <= 1'b1;
        wait_n(8);
        chk("lol", pin_b, 1'b1);
        vt.pll_slip[0] <= 1'b0;
        $display("test irq done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        wait_n(6);
        nrst <= 1'b1;
        t_reset();
        t_sync_pin();
        t_sync_sw();
        t_status();
        t_irq();
        results();
    end
    // whole run is well under a thousand cycles
    initial begin
        wait_n(5000);
        n_mismatch++;
        results();
    end
endmodule
